/* tb/sls_host_model.sv */
// Host micro-controller model on the serial pins of the sequencer.
// Assumes the bench calls one task at a time, right after a ref_clk edge.
`timescale 1ns/1ns
module sls_host_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic ref_clk,
  // Serial pins seen from the host
  output logic      host_txd,
  input  wire logic host_rxd
);
  // Line idles high between characters
  initial host_txd = 1'b1;

  // One character at the fixed start-up rate: start, data LSB first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_txd <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask : send

  // Sample each answer bit mid-cell; gives up when no start bit shows
  task automatic recv(output logic [7:0] b, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    b = 8'h00;
    while (host_rxd !== 1'b0 && n < 30 * BIT_CYC) begin
      @(posedge ref_clk);
      n++;
    end
    if (n < 30 * BIT_CYC) begin
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk);
        b[i] = host_rxd;
      end
      repeat (BIT_CYC) @(posedge ref_clk);
      got = (host_rxd === 1'b1);
    end
  endtask : recv

  // Send and listen at once; the tail lets the answer frame finish first
  task automatic xfer(input logic [7:0] c, output logic [7:0] r, output logic got);
    fork
      send(c);
      recv(r, got);
    join
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask : xfer
endmodule : sls_host_model

/* tb/test_startup_link_sequencer.sv */
// Self-checking bench of the start-up and host-link sequencer.
// Assumes the host model is compiled first; counts are shortened.
`timescale 1ns/1ns
module test_startup_link_sequencer;
  import sls_pkg::*;
  localparam int BC = 16;
  localparam int SC = 200;
  localparam int WC = 600;
  logic        ref_clk, resetn, mrst_pin_n, rx_pin, tx_pin;
  logic        card_present, card_fat16, script_found, wav_play;
  logic [31:0] fat_sectors, raw_byte_off, card_byte_addr, card_sector;
  logic [23:0] raw_sector;
  sls_vmode_t  vmode;
  logic [9:0]  custom_w, custom_h;
  logic        vmode_ok, video_en, audio_pwm, settle_done, link_synced;
  logic        splash_on, display_blank, script_start, fw_load_req;
  logic [6:0]  volume;
  logic [7:0]  rsp;
  logic        got;
  int          n_errors, comparisons, n_script, n_fw, n_hi;

  sls_startup_seq #(.BIT_CYC(BC), .SETTLE_CYC(SC), .WAIT_CYC(WC)) uut (
    .ref_clk, .resetn, .mrst_pin_n, .rx_pin, .tx_pin, .card_present, .card_fat16,
    .script_found, .fat_sectors, .raw_byte_off, .raw_sector, .card_byte_addr,
    .card_sector, .vmode, .custom_w, .custom_h, .vmode_ok, .video_en, .wav_play,
    .volume, .audio_pwm, .settle_done, .link_synced, .splash_on, .display_blank,
    .script_start, .fw_load_req);
  sls_host_model #(.BIT_CYC(BC)) host (.ref_clk, .host_txd(rx_pin), .host_rxd(tx_pin));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Pulse counters, since the pulses last one cycle only
  always @(posedge ref_clk) begin
    if (script_start === 1'b1) n_script++;
    if (fw_load_req === 1'b1) n_fw++;
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, a, e);
    end
  endtask : chk

  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Reset is held four cycles, then released on an edge
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    n_script = 0;
  endtask : do_reset

  task automatic t_reset;
    do_reset();
    chk({tx_pin, display_blank, settle_done, link_synced, splash_on}, 5'b11000);
    chk(volume, 7'h40);
  endtask : t_reset

  // A sync byte sent while settling must be dropped; the host ignores its rx meanwhile
  task automatic t_settle;
    fork
      host.send(8'h55);
      repeat (SC - 2) @(posedge ref_clk);
    join
    chk({settle_done, link_synced}, 2'b00);
    repeat (4) @(posedge ref_clk);
    chk(settle_done, 1'b1);
    chk(n_script, 1);
    host.xfer(8'h55, rsp, got);
    chk({got, rsp}, 9'h106);
    chk(link_synced, 1'b1);
    repeat (WC) @(posedge ref_clk);
    chk({splash_on, display_blank}, 2'b01);
  endtask : t_settle

  // Fixed formats plus custom frames on both sides of the pixel limit
  task automatic t_video;
    for (int i = 0; i < 5; i++) begin
      vmode <= sls_vmode_t'(i < 3 ? i : 3);
      custom_w <= 10'h2d0;
      custom_h <= (i == 4) ? 10'h241 : 10'h240;
      repeat (3) @(posedge ref_clk);
      chk({vmode_ok, video_en}, (i != 4) ? 2'b11 : 2'b00);
    end
  endtask : t_video

  // Offsets at the top of their ranges, sector sum wrapping
  task automatic t_addr;
    fat_sectors <= 32'hffff_f000;
    raw_sector <= 24'hff_ffff;
    raw_byte_off <= 32'hffff_ffff;
    repeat (2) @(posedge ref_clk);
    chk(card_byte_addr, 32'hffff_ffff);
    chk(card_sector, 32'h00ff_efff);
  endtask : t_addr

  task automatic t_cmds;
    logic [7:0] vv [4];
    vv = '{8'h08, 8'h7f, 8'h07, 8'h80};
    for (int i = 0; i < 4; i++) begin
      host.xfer(8'h76, rsp, got);
      chk(got, 1'b0);
      host.xfer(vv[i], rsp, got);
      chk(rsp, (i < 2) ? 8'h06 : 8'h15);
      chk(volume, (i == 0) ? 7'h08 : 7'h7f);
    end
    host.xfer(8'h7a, rsp, got);
    chk({rsp, n_fw[1:0]}, 10'h019);
    // Playback keeps going while a command is handled
    wav_play <= 1'b1;
    n_hi = 0;
    fork
      host.xfer(8'h00, rsp, got);
      repeat (129) begin  // First sample predates wav_play, then one full 128-step period
        @(posedge ref_clk);
        n_hi += (audio_pwm === 1'b1);
      end
    join
    wav_play <= 1'b0;
    chk(rsp, 8'h15);
    chk(n_hi, 127);
  endtask : t_cmds

  // Short low pulse is filtered, a long one restarts everything
  task automatic t_mrst;
    mrst_pin_n <= 1'b0;
    repeat (50) @(posedge ref_clk);
    mrst_pin_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({settle_done, link_synced}, 2'b11);
    mrst_pin_n <= 1'b0;
    repeat (110) @(posedge ref_clk);
    chk({settle_done, link_synced, display_blank, volume}, {3'b001, 7'h40});
    mrst_pin_n <= 1'b1;
    repeat (SC + 10) @(posedge ref_clk);
    chk(settle_done, 1'b1);
    chk(n_script, 2);
  endtask : t_mrst

  // No sync inside the window: splash, and a late sync is still answered
  task automatic t_splash;
    card_present <= 1'b0;
    do_reset();
    repeat (WC - 4) @(posedge ref_clk);
    chk({splash_on, display_blank}, 2'b01);
    repeat (8) @(posedge ref_clk);
    chk({splash_on, display_blank}, 2'b10);
    chk(n_script, 0);
    host.xfer(8'h55, rsp, got);
    chk({got, rsp, splash_on}, 10'h20d);
  endtask : t_splash

  // Inputs settle at time zero, then the scenarios run in order
  initial begin
    resetn = 1'b0;
    mrst_pin_n = 1'b1;
    {card_present, card_fat16, script_found, wav_play} = 4'b1110;
    fat_sectors = 32'h0;
    raw_byte_off = 32'h0;
    raw_sector = 24'h0;
    vmode = SLS_VM_VGA;
    custom_w = 10'h0;
    custom_h = 10'h0;
    t_reset();
    t_settle();
    t_video();
    t_addr();
    t_cmds();
    t_mrst();
    t_splash();
    end_sim();
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
endmodule : test_startup_link_sequencer

/* verilog/sls_defs.svh */
// Constants of the start-up and host-link sequencer.
// Assumes a 50 MHz reference clock; included by bare name.
`ifndef SLS_DEFS_SVH
`define SLS_DEFS_SVH
`define SLS_CLK_HZ      50000000
`define SLS_BAUD        9600
`define SLS_SETTLE_MS   500
`define SLS_WAIT_S      5
`define SLS_RST_US      2
`define SLS_SYNC_BYTE   8'h55
`define SLS_ACK_BYTE    8'h06
`define SLS_NAK_BYTE    8'h15
`define SLS_OP_VOLUME   8'h76
`define SLS_OP_FWLOAD   8'h7a
`define SLS_VOL_MIN     7'h08
`define SLS_VOL_MAX     7'h7f
`define SLS_VOL_RESET   7'h40
`define SLS_SECT_SHIFT  9
`define SLS_MAX_PIXELS  19'h65400
`define SLS_QVGA_W      10'h140
`define SLS_QVGA_H      10'h0f0
`define SLS_VGA_W       10'h280
`define SLS_VGA_H       10'h1e0
`define SLS_WVGA_W      10'h320
`define SLS_FRAME_BITS  10
`define SLS_CNT_ONE     28'h0000001
`endif

/* verilog/sls_pkg.sv */
// Types shared by the start-up sequencer and its serial receiver.
// Assumes nothing beyond the constants header.
package sls_pkg;
  // Start-up phase
  typedef enum logic [1:0] {
    SLS_SETTLE = 2'b00,
    SLS_WAIT   = 2'b01,
    SLS_RUN    = 2'b10
  } sls_phase_t;
  // Command parser state
  typedef enum logic [1:0] {
    SLS_CMD_IDLE = 2'b00,
    SLS_CMD_VOL  = 2'b01
  } sls_cmd_t;
  // Video frame format
  typedef enum logic [1:0] {
    SLS_VM_QVGA   = 2'b00,
    SLS_VM_VGA    = 2'b01,
    SLS_VM_WVGA   = 2'b10,
    SLS_VM_CUSTOM = 2'b11
  } sls_vmode_t;
endpackage : sls_pkg

/* verilog/sls_startup_seq.sv */
// Start-up sequencer and host-link bring-up of a serial graphics module.
// Assumes one 50 MHz clock, a host on the serial pins, and card and video
// engines that act on the flags and addresses produced here.
// Functional notes
// - Sync byte 55h at 9600 baud is answered with ACK 06h.
// - Link starts at 9600 bps on both sides.
// - Screen blank up to 5 s; splash shown if no sync came.
// - Sync inside the window keeps the display blank, no splash.
// - At power-up with FAT card, start script file if present.
// - Volume commands accept 8 to 127 and drive the PWM audio.
// - Wave playback runs alongside command handling.
// - Raw byte access spans a 32-bit byte address space.
// - Raw sector access spans 2^24 sectors of 512 bytes.
// - FAT partition first, raw area follows it; card_byte_addr passes raw_byte_off through without the FAT offset.
// - Frames 320x240, 640x480, 800x480, custom up to 414720 pixels.
// - Video drives RGB, sync and pixel clock signals.
// - Firmware replacement only via the serial port.
// - Unknown or failed commands answered with NAK 15h.
// - Characters are 8 data bits, no parity, one stop bit.
// - Least significant data bit sent first after start bit.
// - Reset pin low longer than 2 us restarts the sequence.
`timescale 1ns/1ns
`include "sls_defs.svh"
module sls_startup_seq #(
  parameter int BIT_CYC    = `SLS_CLK_HZ / `SLS_BAUD,
  parameter int SETTLE_CYC = `SLS_SETTLE_MS * (`SLS_CLK_HZ / 1000),
  parameter int WAIT_CYC   = `SLS_WAIT_S * `SLS_CLK_HZ
) (
  // Clock and reset
  input  logic               ref_clk,
  input  logic               resetn,
  // Module pins
  input  logic               mrst_pin_n,
  input  logic               rx_pin,
  output logic               tx_pin,
  // Card status
  input  logic               card_present,
  input  logic               card_fat16,
  input  logic               script_found,
  // Raw partition addressing
  input  logic [31:0]        fat_sectors,
  input  logic [31:0]        raw_byte_off,
  input  logic [23:0]        raw_sector,
  output logic [31:0]        card_byte_addr,
  output logic [31:0]        card_sector,
  // Video format
  input  sls_pkg::sls_vmode_t vmode,
  input  logic [9:0]         custom_w,
  input  logic [9:0]         custom_h,
  output logic               vmode_ok,
  output logic               video_en,
  // Audio
  input  logic               wav_play,
  output logic [6:0]         volume,
  output logic               audio_pwm,
  // Sequencer status
  output logic               settle_done,
  output logic               link_synced,
  output logic               splash_on,
  output logic               display_blank,
  output logic               script_start,
  output logic               fw_load_req
);
  import sls_pkg::*;
  localparam int RST_CYC = (`SLS_RST_US * (`SLS_CLK_HZ / 1000) + 999) / 1000;
  // Elaboration checks: the counters below cannot serve larger values
  if (SETTLE_CYC < 1 || WAIT_CYC <= SETTLE_CYC || WAIT_CYC > 268435455 || RST_CYC > 255) begin : g_bad_counts
    $error("start-up counts out of range");
  end
  if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
    $error("BIT_CYC out of range");
  end

  // Pixel count of a format, used for the custom size limit
  function automatic logic [19:0] frame_pixels(input logic [9:0] w, input logic [9:0] h);
    frame_pixels = {10'h000, w} * {10'h000, h}; // Widened first so no product bit is lost
  endfunction : frame_pixels

  // Pin synchronisers
  logic [1:0] mrst_sync_q;
  logic [1:0] rx_sync_q;
  always_ff @(posedge ref_clk) begin
    mrst_sync_q <= {mrst_sync_q[0], mrst_pin_n};
    rx_sync_q   <= {rx_sync_q[0], rx_pin};
  end

  // Reset pin filter: only a low longer than the minimum restarts us
  logic [7:0] rlow_q;
  logic       restart_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rlow_q    <= 8'h00;
      restart_q <= 1'b0;
    end else if (mrst_sync_q[1]) begin
      rlow_q    <= 8'h00;
      restart_q <= 1'b0;
    end else if (rlow_q != 8'(RST_CYC)) begin
      rlow_q <= rlow_q + 8'h01;
    end else begin
      restart_q <= 1'b1;
    end
  end
  logic run_n;
  assign run_n = !resetn || restart_q;

  logic [7:0] rx_data;
  logic       rx_valid;
  sls_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk  (ref_clk),
    .resetn   (resetn && !restart_q),
    .rxd      (rx_sync_q[1]),
    .rx_data  (rx_data),
    .rx_valid (rx_valid)
  );

  // One counter times both the settle period and the splash window
  sls_phase_t  phase_q;
  logic [27:0] up_q;
  always_ff @(posedge ref_clk) begin
    if (run_n) begin
      phase_q <= SLS_SETTLE;
      up_q    <= 28'h0000000;
    end else begin
      if (phase_q != SLS_RUN) up_q <= up_q + `SLS_CNT_ONE;
      if (phase_q == SLS_SETTLE && up_q == 28'(SETTLE_CYC - 1)) phase_q <= SLS_WAIT;
      if (phase_q == SLS_WAIT && up_q == 28'(WAIT_CYC - 1)) phase_q <= SLS_RUN;
    end
  end

  // Display and script control follow the phase
  always_ff @(posedge ref_clk) begin
    script_start <= 1'b0;
    if (run_n) begin
      settle_done   <= 1'b0;
      splash_on     <= 1'b0;
      display_blank <= 1'b1;
    end else begin
      if (phase_q == SLS_SETTLE && up_q == 28'(SETTLE_CYC - 1)) begin
        settle_done  <= 1'b1;
        script_start <= card_present && card_fat16 && script_found;
      end
      if (phase_q == SLS_WAIT && up_q == 28'(WAIT_CYC - 1) && !link_synced) begin
        splash_on     <= 1'b1;
        display_blank <= 1'b0;
      end
    end
  end

  // Command parser; a byte is only taken when the transmitter can answer
  sls_cmd_t    cmd_q;
  logic        tx_busy_q;
  logic        tx_go;
  logic [7:0]  tx_byte;
  logic        take;
  assign take = rx_valid && phase_q != SLS_SETTLE && !tx_busy_q;
  always_ff @(posedge ref_clk) begin
    tx_go       <= 1'b0;
    fw_load_req <= 1'b0;
    if (run_n) begin
      cmd_q       <= SLS_CMD_IDLE;
      link_synced <= 1'b0;
      volume      <= `SLS_VOL_RESET;
      tx_byte     <= `SLS_ACK_BYTE;
    end else if (take) begin
      tx_go <= 1'b1;
      case (cmd_q)
        SLS_CMD_IDLE: begin
          if (rx_data == `SLS_SYNC_BYTE) begin
            link_synced <= 1'b1;
            tx_byte     <= `SLS_ACK_BYTE;
          end else if (rx_data == `SLS_OP_VOLUME) begin
            cmd_q <= SLS_CMD_VOL;
            tx_go <= 1'b0;
          end else if (rx_data == `SLS_OP_FWLOAD) begin
            fw_load_req <= 1'b1;
            tx_byte     <= `SLS_ACK_BYTE;
          end else begin
            tx_byte <= `SLS_NAK_BYTE;
          end
        end
        SLS_CMD_VOL: begin
          cmd_q <= SLS_CMD_IDLE;
          if (rx_data[7] == 1'b0 && rx_data[6:0] >= `SLS_VOL_MIN) begin
            volume  <= rx_data[6:0];
            tx_byte <= `SLS_ACK_BYTE;
          end else begin
            tx_byte <= `SLS_NAK_BYTE;
          end
        end
        default: cmd_q <= SLS_CMD_IDLE;
      endcase
    end
  end

  // Transmitter at the start-up rate; idles high, so nothing leaves while settling
  logic [9:0]  tx_sh_q;
  logic [3:0]  tx_bit_q;
  logic [15:0] tx_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (run_n) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3ff;
      tx_bit_q  <= 4'h0;
      tx_cnt_q  <= 16'h0000;
      tx_pin    <= 1'b1;
    end else if (tx_go) begin
      tx_busy_q <= 1'b1;
      tx_sh_q   <= {1'b1, tx_byte, 1'b0};
      tx_bit_q  <= 4'h0;
      tx_cnt_q  <= 16'(BIT_CYC - 1);
      tx_pin    <= 1'b0;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != 16'h0000) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else if (tx_bit_q == 4'h9) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_cnt_q <= 16'(BIT_CYC - 1);
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_pin   <= tx_sh_q[tx_bit_q + 4'h1];
      end
    end
  end

  // Audio PWM runs on its own, so playback never waits on the parser
  logic [6:0] pwm_q;
  always_ff @(posedge ref_clk) begin
    if (run_n) begin
      pwm_q     <= 7'h00;
      audio_pwm <= 1'b0;
    end else begin
      pwm_q     <= pwm_q + 7'h01;
      audio_pwm <= wav_play && (pwm_q < volume);
    end
  end

  // Card addresses: raw sectors sit behind the FAT partition; the byte address is raw_byte_off as given
  always_ff @(posedge ref_clk) begin
    if (run_n) begin
      card_byte_addr <= 32'h00000000;
      card_sector    <= 32'h00000000;
    end else begin
      card_byte_addr <= raw_byte_off;
      card_sector    <= fat_sectors + {8'h00, raw_sector};
    end
  end

  // Frame format check; the pixel engine only runs on a legal format
  logic fmt_ok;
  always_comb begin
    case (vmode)
      SLS_VM_QVGA:   fmt_ok = 1'b1;
      SLS_VM_VGA:    fmt_ok = 1'b1;
      SLS_VM_WVGA:   fmt_ok = 1'b1;
      default:       fmt_ok = frame_pixels(custom_w, custom_h) <= {1'b0, `SLS_MAX_PIXELS};
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (run_n) begin
      vmode_ok <= 1'b0;
      video_en <= 1'b0;
    end else begin
      vmode_ok <= fmt_ok;
      video_en <= fmt_ok && settle_done;
    end
  end

  // Checks
  AST_SETTLE_QUIET: assert property (@(posedge ref_clk) disable iff (run_n)
    phase_q == SLS_SETTLE |-> tx_pin && !tx_busy_q) else $error("transmit during settle");
  AST_SETTLE_IGNORE: assert property (@(posedge ref_clk) disable iff (run_n)
    (rx_valid && phase_q == SLS_SETTLE) |=> !tx_go && $stable(link_synced)) else $error("byte used while settling");
  AST_SYNC_ACK: assert property (@(posedge ref_clk) disable iff (run_n)
    (take && cmd_q == SLS_CMD_IDLE && rx_data == `SLS_SYNC_BYTE) |=> tx_go && tx_byte == `SLS_ACK_BYTE && link_synced)
    else $error("sync not acknowledged");
  AST_UNKNOWN_NAK: assert property (@(posedge ref_clk) disable iff (run_n)
    (take && cmd_q == SLS_CMD_IDLE && rx_data != `SLS_SYNC_BYTE && rx_data != `SLS_OP_VOLUME
     && rx_data != `SLS_OP_FWLOAD) |=> tx_go && tx_byte == `SLS_NAK_BYTE) else $error("unknown byte not refused");
  AST_VOL_RANGE: assert property (@(posedge ref_clk) disable iff (run_n)
    volume >= `SLS_VOL_MIN && volume <= `SLS_VOL_MAX) else $error("volume out of range");
  AST_SPLASH_CAUSE: assert property (@(posedge ref_clk) disable iff (run_n)
    $rose(splash_on) |-> !$past(link_synced) && phase_q == SLS_RUN) else $error("splash without timeout");
  AST_SPLASH_DUE: assert property (@(posedge ref_clk) disable iff (run_n)
    (phase_q == SLS_WAIT && up_q == 28'(WAIT_CYC - 1) && !link_synced) |=> splash_on && !display_blank)
    else $error("splash missing after window");
  AST_NO_SPLASH: assert property (@(posedge ref_clk) disable iff (run_n)
    (link_synced && !splash_on) |=> !splash_on && display_blank) else $error("splash after sync");
  AST_SCRIPT: assert property (@(posedge ref_clk) disable iff (run_n)
    script_start |-> $rose(settle_done) && $past(card_present) && $past(card_fat16) && $past(script_found))
    else $error("bad script start");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!mrst_sync_q[1] && rlow_q == 8'(RST_CYC)) |=> ##[0:1] (phase_q == SLS_SETTLE && !link_synced))
    else $error("long reset pulse did not restart");
  AST_PWM_IDLE: assert property (@(posedge ref_clk) disable iff (run_n)
    !wav_play [*2] |-> !audio_pwm) else $error("audio without playback");
  AST_TX_START: assert property (@(posedge ref_clk) disable iff (run_n)
    tx_go |=> !tx_pin [*2]) else $error("start bit missing");

  COV_SYNC_IN_WINDOW: cover property (@(posedge ref_clk) disable iff (run_n)
    phase_q == SLS_WAIT && $rose(link_synced));
  COV_SPLASH: cover property (@(posedge ref_clk) disable iff (run_n) $rose(splash_on));
  COV_VOLUME: cover property (@(posedge ref_clk) disable iff (run_n) $changed(volume));
  COV_RESTART: cover property (@(posedge ref_clk) $rose(restart_q));
endmodule : sls_startup_seq

/* verilog/sls_uart_rx.sv */
// Serial byte receiver: start bit, 8 data bits LSB first, one stop bit.
// Assumes rxd is already synchronised to ref_clk.
`timescale 1ns/1ns
`include "sls_defs.svh"
module sls_uart_rx #(
  parameter int BIT_CYC = `SLS_CLK_HZ / `SLS_BAUD
) (
  // Clock and reset
  input  logic       ref_clk,
  input  logic       resetn,
  // Serial line
  input  logic       rxd,
  // Received byte
  output logic [7:0] rx_data,
  output logic       rx_valid
);
  import sls_pkg::*;
  localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
  // Elaboration check: the bit counter is 16 bits and needs a real half-bit
  if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
    $error("BIT_CYC out of range");
  end

  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic        busy_q;
  logic [7:0]  sh_q;

  // Sample at mid-bit; a start bit that is gone at mid-bit is a glitch
  always_ff @(posedge ref_clk) begin
    rx_valid <= 1'b0;
    if (!resetn) begin
      cnt_q   <= 16'h0000;
      bit_q   <= 4'h0;
      busy_q  <= 1'b0;
      sh_q    <= 8'h00;
      rx_data <= 8'h00;
    end else if (!busy_q) begin
      if (!rxd) begin
        busy_q <= 1'b1;
        cnt_q  <= HALF;
        bit_q  <= 4'h0;
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else begin
      cnt_q <= FULL;
      bit_q <= bit_q + 4'h1;
      if (bit_q == 4'h0) begin
        if (rxd) busy_q <= 1'b0;
      end else if (bit_q == 4'h9) begin
        busy_q <= 1'b0;
        if (rxd) begin
          rx_valid <= 1'b1;
          rx_data  <= sh_q;
        end
      end else begin
        sh_q <= {rxd, sh_q[7:1]};
      end
    end
  end

  AST_RX_PULSE: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_valid |=> !rx_valid) else $error("rx_valid longer than one cycle");
  AST_RX_STOP: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_valid |-> $past(rxd)) else $error("byte taken without stop bit");
endmodule : sls_uart_rx
